// ### design/fcp_pkg.sv
// Shared constants and types for the filter chip pin interface.
// Notes on behaviour
// - Eleven-bit signed sample feeds the processor ring.
// - Capture clock rising edge registers the sample.
// - Skip high ignores capture clock; low uses it.
// - Eleven output pins carry ring results.
// - Result change gives one phase-two-wide pulse.
// - One instruction per system clock cycle.
// - Derive phases internally, or take external phases.
// - Clock stop low gates all internal clocks.
// - Reference mirror copies the system input clock.
// - Phase mirrors copy internal phase clocks.
// - Programming data travels over eight-bit bus.
// - Address picks location and loads reset address.
// - Write strobe low pulse transfers bus value.
// - Writes only while selected; filtering unaffected.
// - Core select picks the processor written.
// - Resync enable aligns address to internal clocks.
// - Program mode: lane picks byte of word.
// - Coefficient mode: lane picks 1X/3X and half.
// - Reset low loads program counters from reset address.
// - Captured sample re-registered on phase one.
package fcp_pkg;
    localparam int SAMPLE_W = 11;
    localparam int INT_W = 16;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int CORE_SEL_W = 3;
    localparam int LANE_W = 2;
    localparam int PROG_WORD_W = 32;
    localparam int COEF_W = 13;
    localparam int SCALE_W = 3;
    localparam int PROD_W = INT_W + COEF_W;
    localparam int NUM_CORES_DEFAULT = 5;
    localparam int MEM_DEPTH = 16;
    localparam int SYNC_STAGES = 2;
    localparam int IN_SCALE_LSB = 0;
    localparam int OUT_SCALE_LSB = 3;
    localparam int COEF_LO_DATA_LSB = 3;
    localparam int COEF_LO_W = 5;
    localparam int COEF_SHIFT_BIT = 0;
    localparam int LANE_HALF_BIT = 0;
    localparam int LANE_3X_BIT = 1;
    localparam int PROG_COEF_ADDR_LSB = 0;
    localparam int SAMPLE_PAD_W = INT_W - SAMPLE_W;
    localparam int Y_KEEP_LSB = INT_W - SAMPLE_W;
    localparam int PROD_KEEP_LSB = COEF_W - 1;
    localparam logic [ADDR_W-1:0] PC_RESET = 4'h0;
    localparam logic [ADDR_W-1:0] RESET_ADDR_RESET = 4'h0;
    localparam logic [SCALE_W-1:0] SCALE_RESET = 3'h0;

    typedef enum logic [2:0]
    {
        FCP_PULSE_IDLE = 3'b001,
        FCP_PULSE_ARMED = 3'b010,
        FCP_PULSE_HIGH = 3'b100
    } fcp_pulse_t;

    typedef enum logic [3:0]
    {
        FCP_LOAD_NONE = 4'b0001,
        FCP_LOAD_CODE = 4'b0010,
        FCP_LOAD_WEIGHT = 4'b0100,
        FCP_LOAD_SCALE = 4'b1000
    } fcp_load_t;

    typedef struct packed
    {
        logic strobe_n;
        logic dsel_n;
        logic [CORE_SEL_W-1:0] core;
        logic code_sel;
        logic weight_sel;
        logic scale_sel;
        logic [LANE_W-1:0] lane;
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] addr;
        logic resync;
        logic sysclk;
        logic ph1_in;
        logic ph2_in;
        logic ext_sel;
        logic stop_n;
        logic core_reset_n;
        logic skip;
        logic [SAMPLE_W-1:0] sample;
        logic cap_toggle;
    } fcp_pins_t;
endpackage

// ### design/fcp_pin_interface.sv
// Pin-level front end of the multi-core filter chip: sample capture, clocking, programming port.
module fcp_pin_interface #(
    parameter int NUM_CORES = fcp_pkg::NUM_CORES_DEFAULT
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [fcp_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_capture_clock,
    input wire logic capture_clock_skip,
    output logic [fcp_pkg::SAMPLE_W-1:0] result_out,
    output logic result_valid_pulse,
    input wire logic sys_clock_in,
    input wire logic phase_one_input,
    input wire logic phase_two_input,
    input wire logic external_phase_select,
    input wire logic clock_stop_n,
    output logic ref_clock_mirror,
    output logic phase_one_mirror,
    output logic phase_two_mirror,
    input wire logic [fcp_pkg::DATA_W-1:0] prog_data,
    input wire logic [fcp_pkg::ADDR_W-1:0] prog_address,
    input wire logic write_strobe_n,
    input wire logic device_select_n,
    input wire logic [fcp_pkg::CORE_SEL_W-1:0] core_select,
    input wire logic code_load_select,
    input wire logic weight_load_select,
    input wire logic scale_load_select,
    input wire logic address_resync_enable,
    input wire logic [fcp_pkg::LANE_W-1:0] byte_lane_select,
    input wire logic core_reset_n
);

    ////////////////////////////////////////////////////////////////////////////
    // State types.

    typedef struct packed
    {
        logic skip_s1;
        logic skip_s2;
        logic rst_s1;
        logic rst_s2;
        logic [fcp_pkg::SAMPLE_W-1:0] cap_data;
        logic cap_toggle;
    } fcp_link_state_t;

    typedef struct packed
    {
        fcp_pkg::fcp_pins_t pin_s1;
        fcp_pkg::fcp_pins_t pin_s2;
        logic sysclk_prev;
        logic phase_one;
        logic phase_two;
        logic ph1_prev;
        logic strobe_prev;
        logic tog_seen;
        logic [fcp_pkg::ADDR_W-1:0] addr_resync;
        logic [fcp_pkg::SAMPLE_W-1:0] sample_hold;
        logic [fcp_pkg::INT_W-1:0] x_alu;
        logic [NUM_CORES-1:0][fcp_pkg::ADDR_W-1:0] pc;
        logic [NUM_CORES-1:0][fcp_pkg::ADDR_W-1:0] reset_addr;
        logic [NUM_CORES-1:0][fcp_pkg::SCALE_W-1:0] in_scale;
        logic [NUM_CORES-1:0][fcp_pkg::SCALE_W-1:0] out_scale;
        logic [fcp_pkg::SAMPLE_W-1:0] result;
        fcp_pkg::fcp_pulse_t pulse_state;
    } fcp_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: the capture flop runs on the source's own clock.

    fcp_link_state_t lst;
    fcp_link_state_t next_lst;

    always_comb
    begin
        next_lst = lst;
        next_lst.skip_s1 = capture_clock_skip;
        next_lst.skip_s2 = lst.skip_s1;
        next_lst.rst_s1 = rst;
        next_lst.rst_s2 = lst.rst_s1;
        if (lst.rst_s2)
        begin
            next_lst.cap_data = '0;
            next_lst.cap_toggle = 1'b0;
        end
        else if (!lst.skip_s2)
        begin
            // Sample and event toggle change on the same edge; the toggle announces the new word.
            next_lst.cap_data = sample_in;
            next_lst.cap_toggle = ~lst.cap_toggle;
        end
    end

    always_ff @(posedge sample_capture_clock)
    begin
        lst <= next_lst;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program and coefficient memories, one bank per core.

    logic [fcp_pkg::PROG_WORD_W-1:0] prog_mem [NUM_CORES][fcp_pkg::MEM_DEPTH];
    logic [fcp_pkg::COEF_W-1:0] coef_1x_mem [NUM_CORES][fcp_pkg::MEM_DEPTH];
    logic [fcp_pkg::COEF_W-1:0] coef_3x_mem [NUM_CORES][fcp_pkg::MEM_DEPTH];
    logic coef_shift_mem [NUM_CORES][fcp_pkg::MEM_DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // System domain combinational logic.

    fcp_state_t st;
    fcp_state_t next_st;
    fcp_pkg::fcp_pins_t pins_now;
    fcp_pkg::fcp_load_t load_mode;
    logic write_take;
    logic core_valid;
    logic inst_tick;
    logic [fcp_pkg::ADDR_W-1:0] write_addr;
    logic [fcp_pkg::ADDR_W-1:0] coef_addr;
    logic [fcp_pkg::INT_W-1:0] x_scaled;
    logic signed [fcp_pkg::PROD_W-1:0] product;
    logic [fcp_pkg::INT_W-1:0] y_int;
    logic [fcp_pkg::INT_W-1:0] y_shifted;
    logic [fcp_pkg::SAMPLE_W-1:0] y_pins;

    always_comb
    begin
        pins_now.strobe_n = write_strobe_n;
        pins_now.dsel_n = device_select_n;
        pins_now.core = core_select;
        pins_now.code_sel = code_load_select;
        pins_now.weight_sel = weight_load_select;
        pins_now.scale_sel = scale_load_select;
        pins_now.lane = byte_lane_select;
        pins_now.data = prog_data;
        pins_now.addr = prog_address;
        pins_now.resync = address_resync_enable;
        pins_now.sysclk = sys_clock_in;
        pins_now.ph1_in = phase_one_input;
        pins_now.ph2_in = phase_two_input;
        pins_now.ext_sel = external_phase_select;
        pins_now.stop_n = clock_stop_n;
        pins_now.core_reset_n = core_reset_n;
        pins_now.skip = capture_clock_skip;
        pins_now.sample = sample_in;
        pins_now.cap_toggle = lst.cap_toggle;
    end

    // Priority decode keeps a host that breaks the one-select convention from writing twice.
    always_comb
    begin
        if (st.pin_s2.code_sel)
        begin
            load_mode = fcp_pkg::FCP_LOAD_CODE;
        end
        else if (st.pin_s2.weight_sel)
        begin
            load_mode = fcp_pkg::FCP_LOAD_WEIGHT;
        end
        else if (st.pin_s2.scale_sel)
        begin
            load_mode = fcp_pkg::FCP_LOAD_SCALE;
        end
        else
        begin
            load_mode = fcp_pkg::FCP_LOAD_NONE;
        end
    end

    assign core_valid = 32'(st.pin_s2.core) < NUM_CORES;
    // A write completes on the rising edge that ends the strobe's low pulse.
    assign write_take = st.pin_s2.strobe_n && !st.strobe_prev && !st.pin_s2.dsel_n
        && load_mode != fcp_pkg::FCP_LOAD_NONE && core_valid;
    assign write_addr = st.pin_s2.resync ? st.addr_resync : st.pin_s2.addr;
    // Taken from registered phases so the tick never feeds back into the process that makes it.
    assign inst_tick = st.phase_one && !st.ph1_prev;

    // Datapath of the first core: scaled sample times the 1X coefficient named by the program word.
    assign coef_addr = prog_mem[0][st.pc[0]][fcp_pkg::PROG_COEF_ADDR_LSB +: fcp_pkg::ADDR_W];
    assign x_scaled = $signed({st.sample_hold, fcp_pkg::SAMPLE_PAD_W'(0)}) >>> st.in_scale[0];
    assign product = $signed(st.x_alu) * $signed(coef_1x_mem[0][coef_addr]);
    assign y_int = coef_shift_mem[0][coef_addr]
        ? product[fcp_pkg::PROD_KEEP_LSB - 1 +: fcp_pkg::INT_W]
        : product[fcp_pkg::PROD_KEEP_LSB +: fcp_pkg::INT_W];
    assign y_shifted = y_int << st.out_scale[0];
    assign y_pins = y_shifted[fcp_pkg::Y_KEEP_LSB +: fcp_pkg::SAMPLE_W];

    always_comb
    begin
        next_st = st;
        next_st.pin_s1 = pins_now;
        next_st.pin_s2 = st.pin_s1;
        next_st.sysclk_prev = st.pin_s2.sysclk;
        next_st.strobe_prev = st.pin_s2.strobe_n;
        next_st.ph1_prev = st.phase_one;

        // Two-phase clocks: when derived internally, one clock of dead time after each sysclk edge keeps them apart; external phases are copied as driven.
        if (!st.pin_s2.stop_n)
        begin
            next_st.phase_one = 1'b0;
            next_st.phase_two = 1'b0;
        end
        else if (st.pin_s2.ext_sel)
        begin
            next_st.phase_one = st.pin_s2.ph1_in;
            next_st.phase_two = st.pin_s2.ph2_in;
        end
        else
        begin
            next_st.phase_one = st.pin_s2.sysclk && st.sysclk_prev;
            next_st.phase_two = !st.pin_s2.sysclk && !st.sysclk_prev;
        end

        // Sample path: either the captured word or the directly synchronised pins.
        if (st.pin_s2.skip)
        begin
            next_st.sample_hold = st.pin_s2.sample;
        end
        else if (st.pin_s2.cap_toggle != st.tog_seen)
        begin
            next_st.sample_hold = lst.cap_data;
        end
        next_st.tog_seen = st.pin_s2.cap_toggle;

        if (inst_tick)
        begin
            next_st.addr_resync = st.pin_s2.addr;
            next_st.x_alu = x_scaled;
            for (int i = 0; i < NUM_CORES; i++)
            begin
                next_st.pc[i] = st.pc[i] + fcp_pkg::ADDR_W'(1);
            end
        end

        if (!st.pin_s2.core_reset_n)
        begin
            next_st.pc = st.reset_addr;
        end

        if (write_take && load_mode == fcp_pkg::FCP_LOAD_SCALE)
        begin
            next_st.in_scale[st.pin_s2.core] = st.pin_s2.data[fcp_pkg::IN_SCALE_LSB +: fcp_pkg::SCALE_W];
            next_st.out_scale[st.pin_s2.core] = st.pin_s2.data[fcp_pkg::OUT_SCALE_LSB +: fcp_pkg::SCALE_W];
            next_st.reset_addr[st.pin_s2.core] = write_addr;
        end

        // Result pulse spans the next whole phase-two high time after a change.
        case (st.pulse_state)
            fcp_pkg::FCP_PULSE_IDLE:
            begin
                if (inst_tick && y_pins != st.result)
                begin
                    next_st.result = y_pins;
                    next_st.pulse_state = fcp_pkg::FCP_PULSE_ARMED;
                end
            end
            fcp_pkg::FCP_PULSE_ARMED:
            begin
                if (next_st.phase_two && !st.phase_two)
                begin
                    next_st.pulse_state = fcp_pkg::FCP_PULSE_HIGH;
                end
            end
            fcp_pkg::FCP_PULSE_HIGH:
            begin
                if (!next_st.phase_two)
                begin
                    next_st.pulse_state = fcp_pkg::FCP_PULSE_IDLE;
                end
            end
            default:
            begin
                next_st.pulse_state = fcp_pkg::FCP_PULSE_IDLE;
            end
        endcase

        if (rst)
        begin
            next_st = '0;
            next_st.strobe_prev = 1'b1;
            next_st.pc = {NUM_CORES{fcp_pkg::PC_RESET}};
            next_st.reset_addr = {NUM_CORES{fcp_pkg::RESET_ADDR_RESET}};
            next_st.in_scale = {NUM_CORES{fcp_pkg::SCALE_RESET}};
            next_st.out_scale = {NUM_CORES{fcp_pkg::SCALE_RESET}};
            next_st.pulse_state = fcp_pkg::FCP_PULSE_IDLE;
        end
    end

    always_ff @(posedge clock)
    begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory writes from the programming port.

    always_ff @(posedge clock)
    begin
        if (write_take && load_mode == fcp_pkg::FCP_LOAD_CODE)
        begin
            prog_mem[st.pin_s2.core][write_addr][st.pin_s2.lane * fcp_pkg::DATA_W +: fcp_pkg::DATA_W]
                <= st.pin_s2.data;
        end
        if (write_take && load_mode == fcp_pkg::FCP_LOAD_WEIGHT)
        begin
            if (st.pin_s2.lane[fcp_pkg::LANE_HALF_BIT])
            begin
                if (st.pin_s2.lane[fcp_pkg::LANE_3X_BIT])
                begin
                    coef_3x_mem[st.pin_s2.core][write_addr][fcp_pkg::COEF_W-1:fcp_pkg::COEF_LO_W]
                        <= st.pin_s2.data;
                end
                else
                begin
                    coef_1x_mem[st.pin_s2.core][write_addr][fcp_pkg::COEF_W-1:fcp_pkg::COEF_LO_W]
                        <= st.pin_s2.data;
                end
            end
            else if (st.pin_s2.lane[fcp_pkg::LANE_3X_BIT])
            begin
                coef_3x_mem[st.pin_s2.core][write_addr][fcp_pkg::COEF_LO_W-1:0]
                    <= st.pin_s2.data[fcp_pkg::COEF_LO_DATA_LSB +: fcp_pkg::COEF_LO_W];
            end
            else
            begin
                coef_1x_mem[st.pin_s2.core][write_addr][fcp_pkg::COEF_LO_W-1:0]
                    <= st.pin_s2.data[fcp_pkg::COEF_LO_DATA_LSB +: fcp_pkg::COEF_LO_W];
                coef_shift_mem[st.pin_s2.core][write_addr] <= st.pin_s2.data[fcp_pkg::COEF_SHIFT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops; the pulse output is decoded from the pulse state register.

    assign result_out = st.result;
    assign result_valid_pulse = st.pulse_state == fcp_pkg::FCP_PULSE_HIGH;
    assign ref_clock_mirror = st.pin_s2.sysclk;
    assign phase_one_mirror = st.phase_one;
    assign phase_two_mirror = st.phase_two;

endmodule

// ### verif/fcp_src_model.sv
// Sample source on the link side: drives the sample pins and the capture clock.
module fcp_src_model
(
    input wire logic link_clk,
    output logic [fcp_pkg::SAMPLE_W-1:0] sample_in,
    output logic sample_capture_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic gate = 1'b0;
    initial sample_in = '0;
    // The capture clock only runs inside a frame and stands low between frames.
    assign sample_capture_clock = link_clk & gate;
    task automatic send(input logic [fcp_pkg::SAMPLE_W-1:0] v, input bit hold);
        @(negedge link_clk);
        sample_in = v;
        gate = 1'b1;
        @(negedge link_clk);
        gate = 1'b0;
        // Unless hold is set, the pins stop carrying the sample one link clock after the frame is over.
        if (!hold)
        begin
            @(negedge link_clk);
            sample_in = ~v;
        end
    endtask
endmodule

// ### verif/fcp_pin_interface_chk.sv
// Concurrent checks on the pin interface outputs.
module fcp_pin_interface_chk
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [fcp_pkg::SAMPLE_W-1:0] result_out,
    input wire logic result_valid_pulse,
    input wire logic sys_clock_in,
    input wire logic clock_stop_n,
    input wire logic ref_clock_mirror,
    input wire logic phase_one_mirror,
    input wire logic phase_two_mirror
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] since_rst;
    logic [4:0] since_chg;
    default clocking cb @(posedge clock);
    endclocking
    always_ff @(posedge clock)
    begin
        since_rst <= rst ? 3'h0 : since_rst + {2'h0, since_rst != 3'h7};
        since_chg <= rst ? 5'h1F : $changed(result_out) ? 5'h00 : since_chg + {4'h0, since_chg != 5'h1F};
    end
    sequence s_stopped;
        !clock_stop_n [*5];
    endsequence
    sequence s_pulse_soon;
        ##[1:24] $rose(result_valid_pulse);
    endsequence
    a_phase_disjoint: assert property (disable iff (rst) !(phase_one_mirror && phase_two_mirror))
        else $error("phases overlap");
    a_stop_gates: assert property (disable iff (rst) s_stopped |-> !phase_one_mirror && !phase_two_mirror)
        else $error("phases run while stopped");
    a_stop_holds: assert property (disable iff (rst) s_stopped |=> $stable(result_out))
        else $error("result moved while stopped");
    a_stop_no_pulse: assert property (disable iff (rst) s_stopped |-> !result_valid_pulse)
        else $error("pulse while stopped");
    a_ref_mirror: assert property (disable iff (rst) since_rst > 3'h3 |-> ref_clock_mirror == $past(sys_clock_in, 2))
        else $error("reference mirror wrong");
    a_pulse_follows: assert property (disable iff (rst) $changed(result_out) && clock_stop_n |-> s_pulse_soon)
        else $error("change without pulse");
    a_pulse_cause: assert property (disable iff (rst) $rose(result_valid_pulse) |-> since_chg <= 5'h10)
        else $error("pulse without change");
    a_rst_clears: assert property (rst |=> result_out == '0 && !result_valid_pulse && !ref_clock_mirror)
        else $error("reset left outputs set");
endmodule

// ### verif/fcp_pin_interface_tb.sv
// Self-checking bench for the filter chip pin interface.
module fcp_pin_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] M_CODE = 3'h4, M_WGT = 3'h2, M_SCL = 3'h1;
    logic clock = 1'b0, link_clk = 1'b0, rst = 1'b1, sys_clock_in = 1'b0;
    logic [10:0] sample_in, result_out;
    logic sample_capture_clock, result_valid_pulse, ref_clock_mirror, phase_one_mirror, phase_two_mirror, prev;
    logic capture_clock_skip = 1'b0, external_phase_select = 1'b0, clock_stop_n = 1'b0;
    logic phase_one_input = 1'b0, phase_two_input = 1'b0, write_strobe_n = 1'b1, device_select_n = 1'b1;
    logic code_load_select = 1'b0, weight_load_select = 1'b0, scale_load_select = 1'b0;
    logic address_resync_enable = 1'b0, core_reset_n = 1'b0;
    logic [7:0] prog_data = 8'h00;
    logic [3:0] prog_address = 4'h0;
    logic [2:0] core_select = 3'h0;
    logic [1:0] byte_lane_select = 2'h0;
    logic [2:0] ref_m [4] = '{M_WGT, 3'h0, M_WGT, M_WGT};
    logic [2:0] ref_c [4] = '{3'h0, 3'h0, 3'h1, 3'h0};
    logic [1:0] ref_l [4] = '{2'h1, 2'h1, 2'h1, 2'h3};
    logic ref_s [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    logic [1:0] ph_pat [3] = '{2'h2, 2'h1, 2'h0};
    int n_mismatch = 0, samples_checked = 0, sdiv = 0;
    int i, t, n, pw, p2, s;
    fcp_pin_interface i_fcp_pin_interface
    (
        .clock, .rst, .sample_in, .sample_capture_clock, .capture_clock_skip, .result_out, .result_valid_pulse,
        .sys_clock_in, .phase_one_input, .phase_two_input, .external_phase_select, .clock_stop_n,
        .ref_clock_mirror, .phase_one_mirror, .phase_two_mirror, .prog_data, .prog_address, .write_strobe_n,
        .device_select_n, .core_select, .code_load_select, .weight_load_select, .scale_load_select,
        .address_resync_enable, .byte_lane_select, .core_reset_n
    );
    fcp_src_model i_fcp_src_model (.link_clk, .sample_in, .sample_capture_clock);
    ////////////////////////////////////////
    initial forever #10 clock = ~clock;
    initial
    begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    // The system clock pin runs at one eighth of the bench clock.
    always @(posedge clock)
    begin
        #1;
        sdiv = sdiv + 1;
        if (sdiv % 4 == 0)
            sys_clock_in = ~sys_clock_in;
    end
    ////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [10:0] model(input int smp, input int half, input int si, input int so);
        int y;
        y = (smp * 32) >>> si;
        y = half ? y >>> 1 : y;
        y = y * (2 ** so);
        return y[15:5];
    endfunction
    task automatic wr(input logic [2:0] m, input logic [2:0] c, input logic [1:0] ln, input logic [7:0] d,
                      input logic [3:0] a, input logic sel_n);
        {code_load_select, weight_load_select, scale_load_select} = m;
        core_select = c;
        byte_lane_select = ln;
        prog_data = d;
        prog_address = a;
        device_select_n = sel_n;
        // Ten clocks before the strobe let a resynchronised address follow the pins.
        tick(10);
        write_strobe_n = 1'b0;
        tick(3);
        write_strobe_n = 1'b1;
        tick(4);
    endtask
    task automatic wait_res(input logic [10:0] e);
        for (t = 0; t < 80 && result_out !== e; t++)
            tick(1);
        check("result", result_out, e);
    endtask
    task automatic put(input int smp, input bit hold, input logic [10:0] e);
        i_fcp_src_model.send(smp[10:0], hold);
        tick(1);
        wait_res(e);
    endtask
    task automatic reset_dut();
        rst = 1'b1;
        fork
            tick(6);
            repeat (3) i_fcp_src_model.send(11'h000, 1'b1);
        join
        check("reset_result", result_out, 11'h000);
        rst = 1'b0;
        // Two more capture edges flush the link side's copy of reset.
        repeat (2) i_fcp_src_model.send(11'h000, 1'b1);
        tick(3);
    endtask
    ////////////////////////////////////////
    initial
    begin
        s = $urandom(10460);
        reset_dut();
        // Program, coefficient and scale loads with clocks held and unsynchronised addressing.
        for (i = 0; i < 16; i++)
            wr(M_CODE, 3'h0, 2'h0, (i == 5) ? 8'h01 : 8'h00, i[3:0], 1'b0);
        wr(M_WGT, 3'h0, 2'h0, 8'h01, 4'h0, 1'b0);
        wr(M_WGT, 3'h0, 2'h1, 8'h40, 4'h0, 1'b0);
        wr(M_WGT, 3'h0, 2'h0, 8'h00, 4'h1, 1'b0);
        wr(M_WGT, 3'h0, 2'h1, 8'h40, 4'h1, 1'b0);
        wr(M_SCL, 3'h0, 2'h0, 8'h00, 4'h5, 1'b0);
        clock_stop_n = 1'b1;
        address_resync_enable = 1'b1;
        tick(10);
        for (i = 0; i < 4; i++)
        begin
            s = $urandom_range(511) - 256;
            put(s, 1'b0, model(s, 1, 0, 0));
        end
        $display("test capture done");
        wr(M_SCL, 3'h0, 2'h0, 8'h08, 4'h0, 1'b0);
        for (i = 0; i < 4; i++)
            wr(ref_m[i], ref_c[i], ref_l[i], 8'h7F, 4'h0, ref_s[i]);
        capture_clock_skip = 1'b1;
        s = $urandom_range(511) - 256;
        put(s, 1'b1, model(s, 0, 0, 1));
        capture_clock_skip = 1'b0;
        $display("test programming done");
        core_reset_n = 1'b1;
        n = 0;
        repeat (80)
        begin
            prev = phase_one_mirror;
            tick(1);
            n += (!prev && phase_one_mirror) ? 1 : 0;
        end
        check("instr_rate", n, 10);
        for (t = 0; t < 20 && result_valid_pulse === 1'b1; t++)
            tick(1);
        for (t = 0; t < 200 && result_valid_pulse !== 1'b1; t++)
            tick(1);
        for (pw = 0; pw < 20 && result_valid_pulse === 1'b1; pw++)
            tick(1);
        for (t = 0; t < 20 && phase_two_mirror !== 1'b1; t++)
            tick(1);
        for (p2 = 0; p2 < 20 && phase_two_mirror === 1'b1; p2++)
            tick(1);
        check("pulse_width", pw, p2);
        core_reset_n = 1'b0;
        tick(30);
        external_phase_select = 1'b1;
        for (i = 0; i < 3; i++)
        begin
            {phase_one_input, phase_two_input} = ph_pat[i];
            tick(8);
            check("phase_mirrors", {phase_one_mirror, phase_two_mirror}, ph_pat[i]);
        end
        external_phase_select = 1'b0;
        $display("test clocking done");
        n = s;
        clock_stop_n = 1'b0;
        tick(8);
        s = $urandom_range(511) - 256;
        i_fcp_src_model.send(s[10:0], 1'b0);
        tick(40);
        check("stopped_result", result_out, model(n, 0, 0, 1));
        clock_stop_n = 1'b1;
        wait_res(model(s, 0, 0, 1));
        reset_dut();
        s = $urandom_range(511) - 256;
        put(s, 1'b0, model(s, 0, 0, 0));
        $display("test stop and reset done");
        final_report();
    end
    // The limit is roughly twenty times the expected length of the whole sequence.
    initial
    begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule
bind fcp_pin_interface fcp_pin_interface_chk i_fcp_pin_interface_chk (.clock, .rst, .result_out,
    .result_valid_pulse, .sys_clock_in, .clock_stop_n, .ref_clock_mirror, .phase_one_mirror, .phase_two_mirror);
